//--- verilog/riac_top.v
// Reference input action control bank: flag clears, phase offset steps,
// profile start and timeout strobes, monitor override and bypass bits.
// Assumes a classic Wishbone master on clk_i; event inputs are pins.
//
// The Wishbone slave port was decided locally.
`timescale 1ns/1ps
`include "riac_consts.vh"
module riac_top (
   input  wire        clk_i,
   input  wire        rst_i,
   input  wire        ce_i,
   input  wire        cyc_i,
   input  wire        stb_i,
   input  wire        we_i,
   input  wire [3:0]  sel_i,
   input  wire [15:0] adr_i,
   input  wire [31:0] dat_i,
   output reg  [31:0] dat_o,
   output reg         ack_o,
   input  wire [31:0] ref_evt_i,
   input  wire [31:0] ref_evt_mask_i,
   input  wire [7:0]  mon_fault_i,
   output reg  [7:0]  mon_fault_o,
   output reg  [7:0]  mon_bypass_o,
   output reg  [7:0]  prof_start_o,
   output reg  [7:0]  force_timeout_o,
   output reg  [15:0] phase_offset_o,
   output reg         irq_o
);
   // ==========================================================
   // Input synchronisers
   // ==========================================================
   // Event inputs arrive as pins; each is a pulse or level from the monitors.
   reg  [31:0] evt_s1_q;
   reg  [31:0] evt_s2_q;
   reg  [31:0] evt_prev_q;
   reg  [31:0] emask_s1_q;
   reg  [31:0] emask_s2_q;
   reg  [7:0]  flt_s1_q;
   reg  [7:0]  flt_s2_q;
   wire [31:0] evt_rise = evt_s2_q & ~evt_prev_q & ~emask_s2_q;

   always @(posedge clk_i) begin
      if (rst_i) begin
         evt_s1_q   <= `RIAC_ZERO32;
         evt_s2_q   <= `RIAC_ZERO32;
         evt_prev_q <= `RIAC_ZERO32;
         emask_s1_q <= `RIAC_ONES32;
         emask_s2_q <= `RIAC_ONES32;
         flt_s1_q   <= `RIAC_ZERO8;
         flt_s2_q   <= `RIAC_ZERO8;
      end else if (ce_i) begin
         evt_s1_q   <= ref_evt_i;
         evt_s2_q   <= evt_s1_q;
         evt_prev_q <= evt_s2_q;
         emask_s1_q <= ref_evt_mask_i;
         emask_s2_q <= emask_s1_q;
         flt_s1_q   <= mon_fault_i;
         flt_s2_q   <= flt_s1_q;
      end
   end

   // ==========================================================
   // Bus decode
   // ==========================================================
   function [11:0] word_idx;
      input [15:0] adr;
      begin
         word_idx = adr[13:2];
      end
   endfunction

   wire        req    = cyc_i & stb_i & ~ack_o;
   wire        wr     = req & we_i & sel_i[0];
   wire [11:0] idx    = word_idx(adr_i);
   wire [7:0]  wb     = dat_i[7:0];
   wire [15:0] wb16   = dat_i[15:0];

   // Write-one strobes exist only in the cycle the write is taken.
   wire [31:0] clr_w;
   assign clr_w[7:0]   = (wr && idx == `RIAC_IDX_AB_CLR) ? wb : `RIAC_ZERO8;
   assign clr_w[15:8]  = (wr && idx == `RIAC_IDX_BB_CLR) ? wb : `RIAC_ZERO8;
   assign clr_w[23:16] = (wr && idx == `RIAC_IDX_CC_CLR) ? wb : `RIAC_ZERO8;
   assign clr_w[31:24] = (wr && idx == `RIAC_IDX_DD_CLR) ? wb : `RIAC_ZERO8;
   wire clr_all = wr && idx == `RIAC_IDX_CLR_ALL && wb[`RIAC_CLR_ALL_BIT];
   wire ph_wr   = wr && idx == `RIAC_IDX_PHASE_CTL;
   wire [15:0] phase_now;

   // ==========================================================
   // Registers
   // ==========================================================
   reg  [31:0] flag_q;
   reg  [7:0]  ovr_q;
   reg  [7:0]  byp_q;
   reg  [15:0] step_q;
   reg  [7:0]  irq_stat_q;
   reg  [7:0]  irq_mask_q;
   wire [31:0] flag_d = (flag_q & ~clr_w & {32{~clr_all}}) | evt_rise;
   // Local events: a flag newly set, per reference group of the eight.
   wire [7:0]  flag_evt;
   assign flag_evt = {|evt_rise[31:28], |evt_rise[27:24], |evt_rise[23:20],
                      |evt_rise[19:16], |evt_rise[15:12], |evt_rise[11:8],
                      |evt_rise[7:4],   |evt_rise[3:0]};
   wire irq_clr_wr = wr && idx == `RIAC_IDX_IRQ_STAT;

   always @(posedge clk_i) begin
      if (rst_i) begin
         flag_q          <= `RIAC_ZERO32;
         ovr_q           <= `RIAC_ZERO8;
         byp_q           <= `RIAC_ZERO8;
         step_q          <= `RIAC_STEP_RESET;
         irq_stat_q      <= `RIAC_ZERO8;
         irq_mask_q      <= `RIAC_ZERO8;
         prof_start_o    <= `RIAC_ZERO8;
         force_timeout_o <= `RIAC_ZERO8;
      end else if (ce_i) begin
         flag_q <= flag_d;
         // Set wins over a simultaneous write-one clear.
         irq_stat_q <= (irq_stat_q & ~(irq_clr_wr ? wb : `RIAC_ZERO8)) | flag_evt;
         // Strobes last one cycle; a zero written starts nothing.
         prof_start_o    <= (wr && idx == `RIAC_IDX_PROF_START) ? wb : `RIAC_ZERO8;
         force_timeout_o <= (wr && idx == `RIAC_IDX_FORCE_TO) ? wb : `RIAC_ZERO8;
         if (wr && idx == `RIAC_IDX_MON_OVR) begin
            ovr_q <= wb;
         end
         if (wr && idx == `RIAC_IDX_MON_BYP) begin
            byp_q <= wb;
         end
         if (wr && idx == `RIAC_IDX_IRQ_MASK) begin
            irq_mask_q <= wb;
         end
         if (wr && idx == `RIAC_IDX_STEP_LO) begin
            step_q[7:0] <= wb;
         end
         if (wr && idx == `RIAC_IDX_STEP_HI) begin
            step_q[15:8] <= wb;
         end
      end
   end

   // ==========================================================
   // Phase offset accumulator
   // ==========================================================
   riac_phase_acc u_acc (
      .clk_i    (clk_i),
      .rst_i    (rst_i),
      .ce_i     (ce_i),
      .zero_i   (ph_wr & wb[`RIAC_PHASE_ZERO_BIT]),
      .dec_i    (ph_wr & wb[`RIAC_PHASE_DEC_BIT]),
      .inc_i    (ph_wr & wb[`RIAC_PHASE_INC_BIT]),
      .step_i   (step_q),
      .offset_o (phase_now)
   );

   // ==========================================================
   // Read mux and outputs
   // ==========================================================
   reg [31:0] rd_d;
   always @* begin
      rd_d = `RIAC_ZERO32;
      case (idx)
         `RIAC_IDX_MON_OVR:    rd_d = {24'h00_0000, ovr_q};
         `RIAC_IDX_MON_BYP:    rd_d = {24'h00_0000, byp_q};
         `RIAC_IDX_FLAG_STAT0: rd_d = {16'h0000, flag_q[15:0]};
         `RIAC_IDX_FLAG_STAT1: rd_d = {16'h0000, flag_q[31:16]};
         `RIAC_IDX_IRQ_STAT:   rd_d = {24'h00_0000, irq_stat_q};
         `RIAC_IDX_IRQ_MASK:   rd_d = {24'h00_0000, irq_mask_q};
         `RIAC_IDX_PH_LO:      rd_d = {24'h00_0000, phase_now[7:0]};
         `RIAC_IDX_PH_HI:      rd_d = {24'h00_0000, phase_now[15:8]};
         `RIAC_IDX_STEP_LO:    rd_d = {24'h00_0000, step_q[7:0]};
         `RIAC_IDX_STEP_HI:    rd_d = {24'h00_0000, step_q[15:8]};
         default:              rd_d = `RIAC_ZERO32;
      endcase
   end

   always @(posedge clk_i) begin
      if (rst_i) begin
         dat_o          <= `RIAC_ZERO32;
         ack_o          <= 1'b0;
         mon_fault_o    <= `RIAC_ZERO8;
         mon_bypass_o   <= `RIAC_ZERO8;
         phase_offset_o <= `RIAC_ZERO16;
         irq_o          <= 1'b0;
      end else if (ce_i) begin
         ack_o          <= req;
         dat_o          <= (req && !we_i) ? rd_d : `RIAC_ZERO32;
         mon_fault_o    <= flt_s2_q & ~ovr_q & ~byp_q;
         mon_bypass_o   <= byp_q;
         phase_offset_o <= phase_now;
         irq_o          <= |(irq_stat_q & ~irq_mask_q);
      end
   end
endmodule

//--- verilog/riac_consts.vh
// Constants of the reference input action control bank.
// Assumes inclusion by bare name from the design files; definitions only.
`ifndef RIAC_CONSTS_VH
`define RIAC_CONSTS_VH
// Printed offsets are not byte addresses: they are word indices.
`define RIAC_IDX_AB_CLR      12'h0A08
`define RIAC_IDX_BB_CLR      12'h0A09
`define RIAC_IDX_CC_CLR      12'h0A0A
`define RIAC_IDX_DD_CLR      12'h0A0B
`define RIAC_IDX_PHASE_CTL   12'h0A0C
`define RIAC_IDX_PROF_START  12'h0A0D
`define RIAC_IDX_FORCE_TO    12'h0A0E
`define RIAC_IDX_MON_OVR     12'h0A0F
`define RIAC_IDX_MON_BYP     12'h0A10
`define RIAC_IDX_FLAG_STAT0  12'h0A20
`define RIAC_IDX_FLAG_STAT1  12'h0A21
`define RIAC_IDX_IRQ_STAT    12'h0A22
`define RIAC_IDX_IRQ_MASK    12'h0A23
`define RIAC_IDX_CLR_ALL     12'h0A24
`define RIAC_IDX_PH_LO       12'h0A25
`define RIAC_IDX_PH_HI       12'h0A26
`define RIAC_IDX_STEP_LO     12'h0A27
`define RIAC_IDX_STEP_HI     12'h0A28
`define RIAC_PHASE_ZERO_BIT  2
`define RIAC_PHASE_DEC_BIT   1
`define RIAC_PHASE_INC_BIT   0
`define RIAC_CLR_ALL_BIT     0
`define RIAC_ZERO8           8'h00
`define RIAC_ZERO16          16'h0000
`define RIAC_ZERO32          32'h0000_0000
`define RIAC_ONES32          32'hFFFF_FFFF
`define RIAC_STEP_RESET      16'h0000
`define RIAC_NUM_EVT         4
`endif

//--- verilog/riac_phase_acc.v
// Incremental phase offset accumulator stepped by one-cycle strobes.
// Assumes the strobes come from logic on the same clock; zero beats step.
`timescale 1ns/1ps
`include "riac_consts.vh"
module riac_phase_acc (
   input  wire        clk_i,
   input  wire        rst_i,
   input  wire        ce_i,
   input  wire        zero_i,
   input  wire        dec_i,
   input  wire        inc_i,
   input  wire [15:0] step_i,
   output reg  [15:0] offset_o
);
   always @(posedge clk_i) begin
      if (rst_i) begin
         offset_o <= `RIAC_ZERO16;
      end else if (ce_i) begin
         if (zero_i) begin
            offset_o <= `RIAC_ZERO16;
         end else if (inc_i && !dec_i) begin
            offset_o <= offset_o + step_i;
         end else if (dec_i && !inc_i) begin
            offset_o <= offset_o - step_i;
         end
      end
   end
endmodule

//--- test/riac_props.sv
// Assertions on the ports of the action control bank.
// Assumes byte address equals word index times four, one clock domain.
`timescale 1ns/1ps
module riac_props (
   input logic        clk_i,
   input logic        rst_i,
   input logic        ce_i,
   input logic        cyc_i,
   input logic        stb_i,
   input logic        we_i,
   input logic [3:0]  sel_i,
   input logic [15:0] adr_i,
   input logic [31:0] dat_i,
   input logic        ack_o,
   input logic [7:0]  mon_bypass_o,
   input logic [7:0]  prof_start_o,
   input logic [7:0]  force_timeout_o,
   input logic [15:0] phase_offset_o
);
   // ====
   // Accepted writes
   logic wr;
   logic ws;
   logic wt;
   logic wp;
   logic wb;
   assign wr = cyc_i & stb_i & ce_i & ~ack_o & we_i & sel_i[0];
   assign ws = wr & (adr_i == 16'h2834);
   assign wt = wr & (adr_i == 16'h2838);
   assign wp = wr & (adr_i == 16'h2830);
   assign wb = wr & (adr_i == 16'h2840);
   default clocking cb @(posedge clk_i); endclocking
   default disable iff (rst_i);
   start_cause_a:
      assert property (ws |=> prof_start_o == $past(dat_i[7:0])) else $error("start bad");
   start_idle_a:
      assert property (!ws |=> prof_start_o == 8'h00) else $error("start stuck");
   tout_cause_a:
      assert property (wt |=> force_timeout_o == $past(dat_i[7:0])) else $error("tout bad");
   tout_idle_a:
      assert property (!wt |=> force_timeout_o == 8'h00) else $error("tout stuck");
   byp_write_a:
      assert property (wb |-> ##2 mon_bypass_o == $past(dat_i[7:0], 2)) else $error("byp bad");
   byp_hold_a:
      assert property (!$stable(mon_bypass_o) |-> $past(wb) || $past(wb, 2))
         else $error("byp moved");
   zero_phase_a:
      assert property (wp && dat_i[2] |-> ##[2:4] phase_offset_o == 16'h0000)
         else $error("zero bad");
   quiet_phase_a:
      assert property (wp && dat_i[2:0] == 3'h0 |-> ##3 $stable(phase_offset_o)[*2])
         else $error("phase moved");
   cover property (wp && dat_i[2]);
   cover property (ws);
   cover property (wb);
endmodule
bind riac_top riac_props u_props (.clk_i(clk_i), .rst_i(rst_i), .ce_i(ce_i), .cyc_i(cyc_i),
   .stb_i(stb_i), .we_i(we_i), .sel_i(sel_i), .adr_i(adr_i), .dat_i(dat_i), .ack_o(ack_o),
   .mon_bypass_o(mon_bypass_o), .prof_start_o(prof_start_o),
   .force_timeout_o(force_timeout_o), .phase_offset_o(phase_offset_o));

//--- test/riac_tb.sv
// Self-checking bench of the action control bank over classic Wishbone.
// Assumes a one-cycle ack per request and synced event pins.
`timescale 1ns/1ps
module tb;
   // ====
   // Design and stimulus
   logic        clk_i = 1'b0;
   logic        rst_i = 1'b1;
   logic        ce_i = 1'b1;
   logic        cyc_i = 1'b0;
   logic        stb_i = 1'b0;
   logic        we_i = 1'b0;
   logic [3:0]  sel_i = 4'hF;
   logic [15:0] adr_i = 16'h0000;
   logic [31:0] dat_i = 32'h0000_0000;
   logic [31:0] ref_evt_i = 32'h0000_0000;
   logic [31:0] ref_evt_mask_i = 32'h0000_0000;
   logic [7:0]  mon_fault_i = 8'h00;
   wire  [31:0] dat_o;
   wire         ack_o, irq_o;
   wire  [7:0]  mon_fault_o, mon_bypass_o, prof_start_o, force_timeout_o;
   wire  [15:0] phase_offset_o;
   logic [31:0] r, s;
   int          n_errors = 0;
   int          n_checks = 0;
   riac_top DUT (.clk_i(clk_i), .rst_i(rst_i), .ce_i(ce_i), .cyc_i(cyc_i), .stb_i(stb_i),
      .we_i(we_i), .sel_i(sel_i), .adr_i(adr_i), .dat_i(dat_i), .dat_o(dat_o), .ack_o(ack_o),
      .ref_evt_i(ref_evt_i), .ref_evt_mask_i(ref_evt_mask_i), .mon_fault_i(mon_fault_i),
      .mon_fault_o(mon_fault_o), .mon_bypass_o(mon_bypass_o), .prof_start_o(prof_start_o),
      .force_timeout_o(force_timeout_o), .phase_offset_o(phase_offset_o), .irq_o(irq_o));
   initial begin
      forever #12.5 clk_i = ~clk_i;
   end
   task automatic stop_test;
      $display("checks %0d errors %0d", n_checks, n_errors);
      if (n_errors == 0 && n_checks > 0) $display("No errors found");
      else $display("Errors were found");
      $finish;
   endtask
   task automatic chk(input logic [31:0] g, input logic [31:0] e);
      n_checks++;
      if (g !== e) begin
         n_errors++;
         $display("[FAIL] %0t got %h exp %h", $time, g, e);
      end
   endtask
   // Strobes are captured with ack because they stand for that one cycle only.
   task automatic wb(input logic w, input logic [11:0] i, input logic [7:0] d);
      int k;
      k = 0;
      cyc_i <= 1'b1;
      stb_i <= 1'b1;
      we_i <= w;
      adr_i <= {2'b00, i, 2'b00};
      dat_i <= {24'h00_0000, d};
      // Ack, read data and strobes are taken at the rising edge that sees ack high.
      do begin
         @(posedge clk_i);
         k++;
      end while (ack_o !== 1'b1 && k < 20);
      if (ack_o !== 1'b1) begin
         n_errors++;
         stop_test();
      end
      r = dat_o;
      s = {16'h0000, prof_start_o, force_timeout_o};
      cyc_i <= 1'b0;
      stb_i <= 1'b0;
      @(posedge clk_i);
   endtask
   task automatic ph(input logic [7:0] d, input logic [15:0] e);
      wb(1'b1, 12'hA0C, d);
      repeat (2) @(posedge clk_i);
      chk({16'h0000, phase_offset_o}, {16'h0000, e});
   endtask
   task automatic evt(input logic [31:0] v);
      ref_evt_i <= v;
      repeat (6) @(posedge clk_i);
   endtask
   // ====
   // Scenarios
   task automatic t_regs;
      mon_fault_i <= 8'hFF;
      wb(1'b0, 12'hA0F, 8'h00); chk(r, 32'h0000_0000);
      wb(1'b0, 12'hA10, 8'h00); chk(r, 32'h0000_0000);
      wb(1'b0, 12'hA08, 8'h00); chk(r, 32'h0000_0000);
      wb(1'b0, 12'h100, 8'h00); chk(r, 32'h0000_0000);
      wb(1'b1, 12'hA0F, 8'h0F);
      wb(1'b1, 12'hA10, 8'h33);
      wb(1'b0, 12'hA0F, 8'h00); chk(r, 32'h0000_000F);
      wb(1'b0, 12'hA10, 8'h00); chk(r, 32'h0000_0033);
      chk({24'h00_0000, mon_fault_o}, 32'h0000_00C0);
      chk({24'h00_0000, mon_bypass_o}, 32'h0000_0033);
   endtask
   task automatic t_strobe;
      for (int i = 0; i < 8; i++) begin
         wb(1'b1, 12'hA0D, 8'h01 << i); chk(s, {16'h0000, 8'h01 << i, 8'h00});
         wb(1'b1, 12'hA0E, 8'h01 << i); chk(s, {24'h00_0000, 8'h01 << i});
      end
      wb(1'b1, 12'hA0D, 8'h00); chk(s, 32'h0000_0000);
      wb(1'b0, 12'hA0D, 8'h00); chk(r, 32'h0000_0000);
   endtask
   task automatic t_phase;
      wb(1'b1, 12'hA27, 8'h05);
      wb(1'b1, 12'hA28, 8'h00);
      ph(8'h01, 16'h0005);
      ph(8'h01, 16'h000A);
      ph(8'h02, 16'h0005);
      ph(8'h04, 16'h0000);
      ph(8'h02, 16'hFFFB);
      ph(8'h00, 16'hFFFB);
      wb(1'b0, 12'hA0C, 8'h00); chk(r, 32'h0000_0000);
   endtask
   task automatic t_irq;
      evt(32'h0000_0040);
      wb(1'b0, 12'hA20, 8'h00); chk(r, 32'h0000_0040);
      chk({31'h0, irq_o}, 32'h0000_0001);
      wb(1'b1, 12'hA23, 8'h02); chk({31'h0, irq_o}, 32'h0000_0000);
      wb(1'b1, 12'hA23, 8'h00); chk({31'h0, irq_o}, 32'h0000_0001);
      wb(1'b1, 12'hA08, 8'h20);
      wb(1'b0, 12'hA20, 8'h00); chk(r, 32'h0000_0040);
      wb(1'b1, 12'hA08, 8'h40);
      wb(1'b0, 12'hA20, 8'h00); chk(r, 32'h0000_0000);
      wb(1'b1, 12'hA22, 8'h02); chk({31'h0, irq_o}, 32'h0000_0000);
      ref_evt_mask_i <= 32'h0000_0001;
      evt(32'h8000_1041);
      wb(1'b0, 12'hA20, 8'h00); chk(r, 32'h0000_1000);
      wb(1'b0, 12'hA21, 8'h00); chk(r, 32'h0000_8000);
      wb(1'b1, 12'hA09, 8'h10);
      wb(1'b0, 12'hA20, 8'h00); chk(r, 32'h0000_0000);
      wb(1'b1, 12'hA24, 8'h01);
      wb(1'b0, 12'hA21, 8'h00); chk(r, 32'h0000_0000);
   endtask
   initial begin
      repeat (6) @(posedge clk_i);
      rst_i <= 1'b0;
      repeat (4) @(posedge clk_i);
      t_regs();
      t_strobe();
      t_phase();
      t_irq();
      stop_test();
   end
endmodule
